// [hw/down_timer.sv]
// loadable millisecond down counter; expired while the count is zero
// assumes tick comes from ms_tick_gen in the same clock domain
module down_timer
  import sleep_ctrl_pkg::*;
(
  input  wire logic ref_clk, // module clock
  input  wire logic srst,    // synchronous reset
  input  wire logic tick,    // ms tick
  timer_if.counter  tif      // load and expiry
);
  logic [TIMER_W-1:0] count_reg;

  // load has priority so a reload never loses to a tick
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      count_reg <= '0;
    else if (tif.load)
      count_reg <= tif.loadValue;
    else if (tick && count_reg != '0)
      count_reg <= count_reg - TIMER_W'(1);
  end

  assign tif.expired = (count_reg == '0);
endmodule : down_timer

// [hw/module_sleep_controller.sv]
// sleep-state sequencer for a battery radio module
// assumes host pins and radio events are synchronous to ref_clk;
// activity, data and sync inputs are one-cycle pulses
module module_sleep_controller
  import sleep_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
)(
  input  wire logic               ref_clk,          // 50 MHz clock
  input  wire logic               srst,             // sync reset
  input  wire logic [3:0]         sleepModeSelect,  // sleep mode
  input  wire logic [TIMER_W-1:0] sleepInterval,    // sleep time, ms
  input  wire logic [TIMER_W-1:0] wakeDuration,     // wake time, ms
  input  wire logic [7:0]         sleepPeriodCount, // periods
  input  wire logic [15:0]        sleepOptions,     // option bits
  input  wire logic [2:0]         sleepPinConfig,   // sleep pin cfg
  input  wire logic [2:0]         selectPinConfig,  // select pin cfg
  input  wire logic               awakeIndicatorEnable, // ind en
  input  wire logic               flowPinEnable,    // cts enable
  input  wire logic               sleepRequestPin,  // high = sleep
  input  wire logic               slaveSelectPin,   // alt request
  input  wire logic               scriptSleepReq,   // script request
  input  wire logic               workPending,      // tx/rx busy
  input  wire logic               serialActivity,   // serial byte
  input  wire logic               radioActivity,    // radio frame
  input  wire logic               pollDataReturned, // queued data
  input  wire logic               syncRx,           // sync received
  input  wire logic [TIMER_W-1:0] syncSleepTime,    // sync sleep
  input  wire logic [TIMER_W-1:0] syncWakeTime,     // sync wake
  input  wire logic               joinRequest,      // joiner seen
  input  wire logic               localSettingsChanged, // new times
  output logic                    ctsN_reg,         // clear to send
  output logic                    awakeInd_reg,     // awake pin
  output logic                    pollRequest_reg,  // poll pulse
  output logic                    syncTx_reg,       // sync pulse
  output logic                    isCoordinator_reg, // coordinator
  output logic                    serialAccept_reg, // take serial
  output logic                    radioAccept_reg,  // take radio
  output logic                    dataTxAllowed_reg, // may send
  output logic [TIMER_W-1:0]      currentSleepQuery_reg, // sleep
  output logic [TIMER_W-1:0]      currentWakeQuery_reg   // wake
);
  // -------------------------------------------------------------------
  // timers
  // -------------------------------------------------------------------
  logic   tick;
  timer_if wakeBus ();
  timer_if sleepBus ();

  ms_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) tickGen (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick)
  );
  down_timer wakeTimer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .tif     (wakeBus)
  );
  down_timer sleepTimer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (tick),
    .tif     (sleepBus)
  );

  // -------------------------------------------------------------------
  // mode decode
  // -------------------------------------------------------------------
  phase_e             phase_reg;
  phase_e             phaseNext;
  logic               asyncMode;
  logic               syncMode;
  logic               pinMode;
  logic               cyclicMode;
  logic               sleepReqEff;
  logic               pinWakeLow;
  logic               coordNext;
  logic               synced_reg;
  logic               netAwake_reg;
  logic               netAwakeNext;
  logic [TIMER_W-1:0] netSleep_reg;
  logic [TIMER_W-1:0] netWake_reg;
  logic [TIMER_W-1:0] sleepEff;
  logic [TIMER_W-1:0] wakeEff;
  logic [7:0]         periods_reg;
  logic               pollNext;
  logic               syncTxNext;
  logic               timedWake;
  logic [TIMER_W-1:0] wakeFloor;
  logic [7:0]         wakeAge_reg;

  assign asyncMode  = sleepModeSelect inside {MODE_PIN, MODE_CYCLIC,
                        MODE_CYC_PIN, MODE_SCRIPT};
  assign syncMode   = sleepModeSelect inside {MODE_SUPPORT,
                        MODE_SYNC_CYC};
  assign pinMode    = sleepModeSelect == MODE_PIN ||
                      sleepModeSelect == MODE_SCRIPT;
  assign cyclicMode = sleepModeSelect == MODE_CYCLIC ||
                      sleepModeSelect == MODE_CYC_PIN;
  assign pinWakeLow = sleepModeSelect == MODE_CYC_PIN && !sleepRequestPin;
  assign coordNext  = syncMode && sleepOptions[OPT_COORD_BIT] &&
                      !sleepOptions[OPT_NONCOORD_BIT];
  // an activity reload must never cut a wake below the poll window
  assign wakeFloor  = (wakeDuration < MIN_WAKE_TICKS) ? MIN_WAKE_TICKS
                                                      : wakeDuration;

  // slave-select stands in only when the sleep pin is unused
  always_comb
  begin
    if (sleepModeSelect == MODE_SCRIPT)
      sleepReqEff = scriptSleepReq;
    else if (sleepPinConfig == PINCFG_IN)
      sleepReqEff = sleepRequestPin;
    else if (sleepPinConfig == PINCFG_OFF && selectPinConfig == PINCFG_IN)
      sleepReqEff = slaveSelectPin;
    else
      sleepReqEff = 1'b0;
  end

  // unsynchronized nodes run on their own settings
  assign sleepEff = (syncMode && synced_reg) ? netSleep_reg
                                             : sleepInterval;
  assign wakeEff  = (syncMode && synced_reg) ? netWake_reg
                                             : wakeDuration;

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  always_comb
  begin
    phaseNext          = phase_reg;
    netAwakeNext       = netAwake_reg;
    wakeBus.load       = 1'b0;
    wakeBus.loadValue  = wakeEff;
    sleepBus.load      = 1'b0;
    sleepBus.loadValue = sleepEff;
    pollNext           = 1'b0;
    syncTxNext         = 1'b0;
    timedWake          = 1'b0;
    case (phase_reg)
      PH_AWAKE:
      begin
        if (pinMode)
        begin
          if (sleepReqEff)
            phaseNext = PH_DRAIN;
        end
        else if (cyclicMode)
        begin
          if (pinWakeLow)
          begin
            wakeBus.load      = 1'b1;
            wakeBus.loadValue = wakeDuration;
          end
          else if (serialActivity || radioActivity || pollDataReturned)
          begin
            wakeBus.load      = 1'b1;
            wakeBus.loadValue = wakeFloor;
          end
          else if (wakeBus.expired)
            phaseNext = PH_DRAIN;
        end
        else if (syncMode)
        begin
          // support nodes track the network phase but stay awake
          if (syncRx)
          begin
            wakeBus.load      = 1'b1;
            wakeBus.loadValue = syncWakeTime;
            netAwakeNext      = 1'b1;
            syncTxNext        = 1'b1;
          end
          else if (netAwake_reg && wakeBus.expired)
          begin
            netAwakeNext  = 1'b0;
            sleepBus.load = 1'b1;
            if (sleepModeSelect == MODE_SYNC_CYC)
              phaseNext = PH_DRAIN;
          end
          else if (!netAwake_reg && sleepBus.expired)
          begin
            netAwakeNext = 1'b1;
            wakeBus.load = 1'b1;
            syncTxNext   = coordNext;
            pollNext     = !coordNext && !synced_reg;
          end
          if (sleepModeSelect == MODE_SUPPORT && joinRequest)
            syncTxNext = 1'b1;
        end
      end
      PH_DRAIN:
      begin
        if (sleepModeSelect == MODE_SUPPORT || !(asyncMode || syncMode))
          phaseNext = PH_AWAKE;
        else if (pinMode && !sleepReqEff)
          phaseNext = PH_AWAKE;
        else if (!workPending)
        begin
          phaseNext     = PH_ASLEEP;
          sleepBus.load = 1'b1;
        end
      end
      default:
      begin
        if (pinMode)
        begin
          if (!sleepReqEff)
            phaseNext = PH_AWAKE;
        end
        else if (cyclicMode)
        begin
          if (pinWakeLow)
          begin
            phaseNext         = PH_AWAKE;
            wakeBus.load      = 1'b1;
            wakeBus.loadValue = wakeDuration;
          end
          else if (sleepBus.expired)
          begin
            phaseNext    = PH_AWAKE;
            pollNext     = 1'b1;
            timedWake    = 1'b1;
            wakeBus.load = 1'b1;
            // a poll and its answer need the short minimum window
            wakeBus.loadValue = sleepOptions[OPT_FULL_WAKE_BIT]
                              ? wakeFloor
                              : MIN_WAKE_TICKS;
          end
        end
        else if (sleepModeSelect == MODE_SYNC_CYC)
        begin
          if (sleepBus.expired)
          begin
            phaseNext    = PH_AWAKE;
            netAwakeNext = 1'b1;
            wakeBus.load = 1'b1;
            syncTxNext   = coordNext;
            pollNext     = !coordNext && !synced_reg;
          end
        end
        else
          phaseNext = PH_AWAKE;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      phase_reg    <= PH_AWAKE;
      netAwake_reg <= 1'b1;
    end
    else
    begin
      phase_reg    <= phaseNext;
      netAwake_reg <= netAwakeNext;
    end
  end

  // -------------------------------------------------------------------
  // network timing: the later change wins, local on a tie
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      synced_reg   <= 1'b0;
      netSleep_reg <= '0;
      netWake_reg  <= '0;
    end
    else if (localSettingsChanged)
    begin
      netSleep_reg <= sleepInterval;
      netWake_reg  <= wakeDuration;
    end
    else if (syncMode && syncRx && phase_reg != PH_ASLEEP)
    begin
      synced_reg   <= 1'b1;
      netSleep_reg <= syncSleepTime;
      netWake_reg  <= syncWakeTime;
    end
  end

  // -------------------------------------------------------------------
  // sleep period count for the awake indicator
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      periods_reg <= PERIOD_CNT_RESET;
    else if (phaseNext == PH_ASLEEP && phase_reg != PH_ASLEEP &&
             awakeInd_reg)
      periods_reg <= PERIOD_CNT_RESET;
    else if (timedWake && periods_reg != 8'hff)
      periods_reg <= periods_reg + 8'h01;
  end

  // -------------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctsN_reg              <= 1'b1;
      awakeInd_reg          <= 1'b0;
      pollRequest_reg       <= 1'b0;
      syncTx_reg            <= 1'b0;
      isCoordinator_reg     <= 1'b0;
      serialAccept_reg      <= 1'b0;
      radioAccept_reg       <= 1'b0;
      dataTxAllowed_reg     <= 1'b0;
      currentSleepQuery_reg <= '0;
      currentWakeQuery_reg  <= '0;
    end
    else
    begin
      ctsN_reg <= !(flowPinEnable && phaseNext == PH_AWAKE);
      // an asleep device must not leave the indicator floating high
      awakeInd_reg <= awakeIndicatorEnable && phaseNext == PH_AWAKE &&
                      (!cyclicMode || pinWakeLow ||
                       periods_reg >= sleepPeriodCount);
      pollRequest_reg   <= pollNext;
      syncTx_reg        <= syncTxNext;
      isCoordinator_reg <= coordNext;
      serialAccept_reg  <= phaseNext != PH_ASLEEP;
      radioAccept_reg   <= phaseNext != PH_ASLEEP;
      dataTxAllowed_reg <= (sleepModeSelect == MODE_SUPPORT)
                         ? netAwakeNext
                         : phaseNext == PH_AWAKE;
      currentSleepQuery_reg <= sleepEff;
      currentWakeQuery_reg  <= wakeEff;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  sequence pinReleased;
    sleepModeSelect == MODE_PIN && phase_reg == PH_ASLEEP && !sleepReqEff;
  endsequence
  sequence readyToTalk;
    phase_reg == PH_AWAKE && (!flowPinEnable || !ctsN_reg);
  endsequence

  drain_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    phase_reg == PH_DRAIN && workPending |=> phase_reg != PH_ASLEEP)
    else $error("slept with work pending");
  noncoord_a: assert property (@(posedge ref_clk) disable iff (srst)
    sleepOptions[OPT_NONCOORD_BIT] |=> !isCoordinator_reg)
    else $error("non-coordinator became coordinator");
  asleep_deaf_a: assert property (@(posedge ref_clk) disable iff (srst)
    phase_reg == PH_ASLEEP |-> !serialAccept_reg && !radioAccept_reg)
    else $error("input accepted while asleep");
  pin_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
    pinReleased |=> readyToTalk)
    else $error("no wake after pin release");
  poll_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
    phase_reg == PH_ASLEEP && cyclicMode && sleepBus.expired &&
    !pinWakeLow |=> pollRequest_reg && phase_reg == PH_AWAKE)
    else $error("cyclic wake without poll");
  // ms ticks since the last timed wake; parked at the top until one comes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      wakeAge_reg <= 8'hff;
    else if (timedWake)
      wakeAge_reg <= 8'h00;
    else if (tick && wakeAge_reg != 8'hff)
      wakeAge_reg <= wakeAge_reg + 8'h01;
  end
  min_wake_a: assert property (@(posedge ref_clk) disable iff (srst)
    phase_reg == PH_AWAKE && sleepModeSelect == MODE_CYCLIC &&
    wakeAge_reg < 8'(MIN_WAKE_MS - 1) |=> phase_reg == PH_AWAKE)
    else $error("cyclic wake shorter than minimum");
  support_awake_a: assert property (@(posedge ref_clk) disable iff (srst)
    sleepModeSelect == MODE_SUPPORT [*2] |-> phase_reg == PH_AWAKE)
    else $error("support node left awake phase");
  join_answer_a: assert property (@(posedge ref_clk) disable iff (srst)
    sleepModeSelect == MODE_SUPPORT && phase_reg == PH_AWAKE &&
    joinRequest |=> syncTx_reg)
    else $error("joiner not answered");
  sync_indicator_a: assert property (@(posedge ref_clk) disable iff (srst)
    $past(sleepModeSelect) == MODE_SYNC_CYC && $past(awakeIndicatorEnable) |->
    awakeInd_reg == (phase_reg == PH_AWAKE))
    else $error("indicator does not follow phase");
  rebroadcast_a: assert property (@(posedge ref_clk) disable iff (srst)
    syncMode && syncRx && phase_reg == PH_AWAKE |=> syncTx_reg)
    else $error("sync not rebroadcast");

endmodule : module_sleep_controller

// [hw/ms_tick_gen.sv]
// millisecond tick generator
// assumes a free-running ref_clk and synchronous active-high srst
module ms_tick_gen
  import sleep_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
)(
  input  wire logic ref_clk, // module clock
  input  wire logic srst,    // synchronous reset
  output logic      tick     // one-cycle pulse per ms
);
  logic [31:0] divCnt_reg;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      divCnt_reg <= 32'h0;
      tick       <= 1'b0;
    end
    else if (divCnt_reg == 32'(TICK_CYCLES - 1))
    begin
      divCnt_reg <= 32'h0;
      tick       <= 1'b1;
    end
    else
    begin
      divCnt_reg <= divCnt_reg + 32'h1;
      tick       <= 1'b0;
    end
  end
endmodule : ms_tick_gen

// [hw/sleep_ctrl_pkg.sv]
// sleep controller constants: modes, option bits, timing, phases
// assumes a single 50 MHz clock and a 1 ms timer tick
package sleep_ctrl_pkg;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int TIMER_W       = 16;
  localparam int MIN_WAKE_MS   = 30;
  // timers tick once per millisecond
  localparam logic [TIMER_W-1:0] MIN_WAKE_TICKS = TIMER_W'(MIN_WAKE_MS);

  // -------------------------------------------------------------------
  // sleep mode selector values
  // -------------------------------------------------------------------
  localparam logic [3:0] MODE_PIN      = 4'h1;
  localparam logic [3:0] MODE_CYCLIC   = 4'h4;
  localparam logic [3:0] MODE_CYC_PIN  = 4'h5;
  localparam logic [3:0] MODE_SCRIPT   = 4'h6;
  localparam logic [3:0] MODE_SUPPORT  = 4'h7;
  localparam logic [3:0] MODE_SYNC_CYC = 4'h8;

  // -------------------------------------------------------------------
  // sleep option bits and pin configuration codes
  // -------------------------------------------------------------------
  localparam int OPT_COORD_BIT     = 0;
  localparam int OPT_NONCOORD_BIT  = 1;
  localparam int OPT_FULL_WAKE_BIT = 8;
  localparam logic [2:0] PINCFG_OFF = 3'h0;
  localparam logic [2:0] PINCFG_IN  = 3'h1;

  localparam logic [7:0] PERIOD_CNT_RESET = 8'h00;

  typedef enum logic [1:0] {PH_AWAKE, PH_DRAIN, PH_ASLEEP} phase_e;

endpackage : sleep_ctrl_pkg

// [hw/timer_if.sv]
// load and expiry handshake between the sequencer and a down timer
// assumes both ends share ref_clk
interface timer_if;
  import sleep_ctrl_pkg::*;
  logic               load;
  logic [TIMER_W-1:0] loadValue;
  logic               expired;

  modport ctrl    (output load, output loadValue, input expired);
  modport counter (input load, input loadValue, output expired);
endinterface : timer_if

// [tb/host_model.sv]
// host side of the sleep pins: request level and serial traffic
// assumes ref_clk shared with the controller, srst active high
module host_model (
  input  wire logic ref_clk,         // module clock
  input  wire logic srst,            // sync reset
  input  wire logic ctsN,            // clear to send from device
  input  wire logic wantSleep,       // bench asks for sleep
  output logic      sleepRequestPin, // high = sleep
  output logic      serialActivity   // one byte sent, pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHAR_CYCLES = 20;
  int   waitCnt;
  logic ctsSeen;
  always @(posedge ref_clk)
  begin
    sleepRequestPin <= #1 srst ? 1'b0 : wantSleep;
  end
  // hold off data until two characters after cts falls
  always @(posedge ref_clk)
  begin
    if (srst || ctsN)
    begin
      waitCnt        <= 0;
      ctsSeen        <= 1'b0;
      serialActivity <= #1 1'b0;
    end
    else if (!ctsSeen && waitCnt == 2 * CHAR_CYCLES)
    begin
      serialActivity <= #1 1'b1;
      ctsSeen        <= 1'b1;
    end
    else
    begin
      waitCnt        <= waitCnt + 1;
      serialActivity <= #1 1'b0;
    end
  end
endmodule : host_model

// [tb/test_module_sleep_controller.sv]
// self-checking bench for the sleep controller, 1 ms = 10 clocks
// assumes the design package and host_model are compiled first
module test_module_sleep_controller;
  import sleep_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 10;
  logic ref_clk, srst, aie, fpe, ssp, ssr, wp, ra, pdr, syncRx, jr, lsc;
  logic wantSleep, sleepRequestPin, serialActivity;
  logic [3:0] mode;
  logic [15:0] si, wd, opt, sst, swt;
  logic [7:0] spc;
  logic [2:0] spcfg, selcfg;
  logic ctsN_reg, awakeInd_reg, pollRequest_reg, syncTx_reg, isCoord;
  logic serialAccept_reg, radioAccept_reg, dtx;
  logic [15:0] csq, cwq;
  logic [31:0] seed = 32'hb97a;
  int errors = 0, n_compared = 0, bad, nTx = 0;

  module_sleep_controller #(.TICK_CYCLES(TC)) DUT (.ref_clk(ref_clk),
    .srst(srst), .sleepModeSelect(mode), .sleepInterval(si),
    .wakeDuration(wd), .sleepPeriodCount(spc), .sleepOptions(opt),
    .sleepPinConfig(spcfg), .selectPinConfig(selcfg),
    .awakeIndicatorEnable(aie), .flowPinEnable(fpe),
    .sleepRequestPin(sleepRequestPin), .slaveSelectPin(ssp),
    .scriptSleepReq(ssr), .workPending(wp),
    .serialActivity(serialActivity), .radioActivity(ra),
    .pollDataReturned(pdr), .syncRx(syncRx), .syncSleepTime(sst),
    .syncWakeTime(swt), .joinRequest(jr), .localSettingsChanged(lsc),
    .ctsN_reg(ctsN_reg), .awakeInd_reg(awakeInd_reg),
    .pollRequest_reg(pollRequest_reg), .syncTx_reg(syncTx_reg),
    .isCoordinator_reg(isCoord), .serialAccept_reg(serialAccept_reg),
    .radioAccept_reg(radioAccept_reg), .dataTxAllowed_reg(dtx),
    .currentSleepQuery_reg(csq), .currentWakeQuery_reg(cwq));
  host_model host (.ref_clk(ref_clk), .srst(srst), .ctsN(ctsN_reg),
    .wantSleep(wantSleep), .sleepRequestPin(sleepRequestPin),
    .serialActivity(serialActivity));

  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] rnd(int lim);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return 16'(1 + seed % lim);
  endfunction : rnd
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic wait_on(ref logic s, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && s !== v; i++)
      tick(1);
    if (s !== v)
    begin
      check("wait bound", 16'h1, 16'h0);
      finish_test();
    end
  endtask : wait_on

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial
  begin
    {srst, aie, fpe, ssp, ssr, wp, ra, pdr, syncRx, jr, lsc} = 11'h400;
    {wantSleep, spc, sst, swt} = '0;
    {mode, si, wd, opt, spcfg, selcfg} = {4'h1, 16'h5, 16'h5, 16'h3,
      3'h1, 3'h0};
    fpe = 1'b1;
    tick(16);
    srst = 1'b0;
    wp = 1'b1;
    wantSleep = 1'b1;
    tick(8);
    check("accept while busy", serialAccept_reg, 1);
    wp = 1'b0;
    wait_on(serialAccept_reg, 1'b0, 4);
    check("radio asleep", radioAccept_reg, 0);
    wantSleep = 1'b0;
    wait_on(ctsN_reg, 1'b0, 4);
    check("accept awake", serialAccept_reg, 1);
    // sleep pin unused, select pin as input: slave-select now acts as the sleep request
    {spcfg, selcfg, ssp} = {3'h0, 3'h1, 1'b1};
    wait_on(serialAccept_reg, 1'b0, 8);
    check("ssel sleep", ctsN_reg, 1);
    {mode, ssr} = {4'h6, 1'b0};
    wait_on(serialAccept_reg, 1'b1, 4);
    ssr = 1'b1;
    wait_on(serialAccept_reg, 1'b0, 4);
    check("script sleep", ctsN_reg, 1);
    {ssp, mode, bad} = {1'b0, 4'h7, 0};
    repeat (200)
    begin
      tick(1);
      if (serialAccept_reg !== 1'b1 || isCoord !== 1'b0)
        bad++;
      if (dtx === 1'b1)
        nTx++;
    end
    check("support awake", bad, 0);
    // equal sleep and wake times: network awake about half the time
    check("support tx", nTx > 60 && nTx < 140, 1);
    jr = 1'b1;
    tick(1);
    check("join sync", syncTx_reg, 1);
    jr = 1'b0;
    {mode, si} = {4'h4, rnd(12)};
    repeat (2)
    begin
      wait_on(pollRequest_reg, 1'b1, (si + 40) * TC);
      check("cts on wake", ctsN_reg, 0);
      bad = 0;
      while (ctsN_reg === 1'b0 && bad < 1000)
      begin
        tick(1);
        bad++;
      end
      check("min wake", bad >= 29 * TC, 1);
    end
    {wantSleep, mode} = {1'b1, 4'h5};
    wait_on(serialAccept_reg, 1'b0, 8);
    wantSleep = 1'b0;
    tick(1);
    wantSleep = 1'b1;
    wait_on(ctsN_reg, 1'b0, 4);
    bad = 0;
    while (ctsN_reg === 1'b0 && bad < 1000)
    begin
      tick(1);
      bad++;
    end
    check("pin wake hold", bad >= (wd - 1) * TC, 1);
    // a one-tick wake could end before the indicator is looked at
    {mode, aie, sst, swt} = {4'h8, 1'b1, rnd(8), rnd(8) + 16'h1};
    wait_on(pollRequest_reg, 1'b1, 50 * TC);
    syncRx = 1'b1;
    tick(1);
    syncRx = 1'b0;
    tick(2);
    check("sleep query", csq, sst);
    check("wake query", cwq, swt);
    check("ind awake", awakeInd_reg, 1);
    wait_on(awakeInd_reg, 1'b0, (swt + 3) * TC);
    tick(2);
    check("sync deaf", serialAccept_reg, 0);
    wait_on(awakeInd_reg, 1'b1, (sst + 3) * TC);
    finish_test();
  end
endmodule : test_module_sleep_controller
